// ### bench/rss_core_asserts.sv
// Concurrent checks on the ports of the rotate/subtract/sleep slice
`timescale 1ns/1ps
`include "rss_map.vh"

module rss_core_asserts #(
    parameter FILE_DEPTH = 128,
    parameter FADR_W = 7,
    parameter PRE_W = 8,
    parameter WDOG_W = 8
) (
    input logic CLK,
    input logic NRST,
    input logic PSEL,
    input logic PENABLE,
    input logic PWRITE,
    input logic [7:0] PADDR,
    input logic [31:0] PWDATA,
    input logic [31:0] PRDATA,
    input logic PREADY,
    input logic PSLVERR,
    input logic WAKE,
    input logic OSC_RUN
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);
    wire acc = PSEL && PENABLE && PREADY;
    wire cmd_wr = acc && PWRITE && PADDR == `RSS_OFS_CMD;
    wire rd_asleep = acc && !PWRITE && !OSC_RUN;
    // ****************************************
    // Sleep, wake, refused commands, wait state and working register read width
    // ****************************************
    AST_SLEEP_STOPS_OSC: assert property (
        cmd_wr && !PSLVERR && PWDATA[9:8] == `RSS_OP_SLEEP |-> ##[1:2] !OSC_RUN)
        else $error("oscillator still running after sleep");
    AST_ASLEEP_HOLDS: assert property (!OSC_RUN && !WAKE |=> !OSC_RUN)
        else $error("left sleep without wake");
    AST_WAKE_RESUMES: assert property (!OSC_RUN && WAKE |=> OSC_RUN)
        else $error("wake did not restart oscillator");
    AST_CMD_REFUSED: assert property (cmd_wr && !OSC_RUN |-> PSLVERR)
        else $error("command accepted while asleep");
    AST_STATUS_ASLEEP: assert property (
        rd_asleep && PADDR == `RSS_OFS_STATUS |-> PRDATA[5:3] == 3'b110)
        else $error("status flags wrong while asleep");
    AST_WDOG_CLEARED: assert property (
        rd_asleep && PADDR == `RSS_OFS_WDOG |-> PRDATA[15:0] == 16'h0000)
        else $error("watchdog not cleared by sleep");
    AST_READY_LATENCY: assert property (
        PSEL && $rose(PENABLE) |-> !PREADY ##1 PREADY ##1 !PREADY)
        else $error("access phase length wrong");
    AST_W_UPPER_ZERO: assert property (
        acc && !PWRITE && PADDR == `RSS_OFS_WREG |-> PRDATA[31:8] == 24'h000000)
        else $error("working register wider than a byte");
    COV_SLEEP: cover property (cmd_wr && !PSLVERR && PWDATA[9:8] == `RSS_OP_SLEEP);
    COV_WAKE: cover property (!OSC_RUN && WAKE);
    COV_REFUSED: cover property (acc && PSLVERR);
endmodule // rss_core_asserts

bind rss_core rss_core_asserts #(.FILE_DEPTH(FILE_DEPTH), .FADR_W(FADR_W), .PRE_W(PRE_W),
    .WDOG_W(WDOG_W)) u_chk (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .WAKE(WAKE), .OSC_RUN(OSC_RUN));

// ### bench/rss_core_tb_top.sv
// Self-checking bench for the rotate/subtract/sleep slice over APB
`timescale 1ns/1ps
`include "rss_map.vh"

module rss_core_tb_top;
    logic CLK = 1'b0;
    logic NRST = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0000_0000;
    logic WAKE = 1'b0;
    wire [31:0] PRDATA;
    wire PREADY, PSLVERR, OSC_RUN;
    logic [31:0] rdat;
    logic rerr;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    localparam logic [7:0] CM = `RSS_OFS_CMD, WR = `RSS_OFS_WREG, ST = `RSS_OFS_STATUS;
    localparam logic [7:0] FA = `RSS_OFS_FADDR, FD = `RSS_OFS_FDATA, WD = `RSS_OFS_WDOG;

    rss_core uut (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .WAKE(WAKE), .OSC_RUN(OSC_RUN));

    always #4 CLK = ~CLK;

    // ****************************************
    // Bus, compare and closing tasks
    // ****************************************
    // Starts one edge late so a release and the next setup never share a time step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        @(posedge CLK);
        while (PREADY !== 1'b1) @(posedge CLK);
        rdat = PRDATA;
        rerr = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Digit carry and zero preset to 1 so a rotate that touches them shows up
    task automatic rot(input logic [1:0] op, input logic dst, input logic [6:0] fa,
        input logic [7:0] fv, input logic cin);
        logic [7:0] r;
        logic co;
        r = (op == `RSS_OP_ROT_LEFT) ? {fv[6:0], cin} : {cin, fv[7:1]};
        co = (op == `RSS_OP_ROT_LEFT) ? fv[7] : fv[0];
        apb(1'b1, FA, {25'h0, fa});
        apb(1'b1, FD, {24'h0, fv});
        apb(1'b1, WR, 32'h0000_005a);
        apb(1'b1, ST, {29'h0, 2'b11, cin});
        apb(1'b1, CM, {22'h0, op, dst, fa});
        apb(1'b0, WR, 32'h0);
        chk(rdat, dst ? 32'h0000_005a : {24'h0, r});
        apb(1'b0, FD, 32'h0);
        chk(rdat, dst ? {24'h0, r} : {24'h0, fv});
        apb(1'b0, ST, 32'h0);
        chk(rdat, {27'h0, 2'b11, 2'b11, co});
    endtask

    task automatic sub(input logic [7:0] w, input logic [7:0] k);
        logic [7:0] r;
        r = k - w;
        apb(1'b1, FD, 32'h0000_003c);
        apb(1'b1, WR, {24'h0, w});
        apb(1'b1, CM, {8'h0, k, 6'h0, `RSS_OP_SUB_LIT, 8'h00});
        apb(1'b0, WR, 32'h0);
        chk(rdat, {24'h0, r});
        apb(1'b0, ST, 32'h0);
        chk(rdat, {27'h0, 2'b11, r == 8'h00, w[3:0] <= k[3:0], w <= k});
        apb(1'b0, FD, 32'h0);
        chk(rdat, 32'h0000_003c);
    endtask

    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            wrap_up();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (5) @(posedge CLK);
        NRST <= 1'b1;
        apb(1'b0, ST, 32'h0);
        chk(rdat, 32'h0000_0018);
        rot(`RSS_OP_ROT_LEFT, 1'b0, 7'd5, 8'he6, 1'b0);
        rot(`RSS_OP_ROT_LEFT, 1'b1, 7'd127, 8'he6, 1'b1);
        rot(`RSS_OP_ROT_RIGHT, 1'b0, 7'd0, 8'h01, 1'b1);
        rot(`RSS_OP_ROT_RIGHT, 1'b1, 7'd64, 8'ha5, 1'b0);
        sub(8'h05, 8'h05);
        sub(8'h06, 8'h05);
        sub(8'h0f, 8'h10);
        sub(8'h00, 8'hff);
        sub(8'hff, 8'h00);
        repeat (300) @(posedge CLK);
        apb(1'b1, CM, {22'h0, `RSS_OP_SLEEP, 8'h00});
        apb(1'b0, ST, 32'h0);
        chk(rdat, 32'h0000_0030);
        chk({31'h0, OSC_RUN}, 32'h0);
        apb(1'b0, WD, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b1, CM, {8'h0, 8'h11, 6'h0, `RSS_OP_SUB_LIT, 8'h00});
        chk({31'h0, rerr}, 32'h1);
        apb(1'b0, WR, 32'h0);
        chk(rdat, 32'h0000_0001);
        WAKE <= 1'b1;
        @(posedge CLK);
        WAKE <= 1'b0;
        @(posedge CLK);
        chk({31'h0, OSC_RUN}, 32'h1);
        apb(1'b0, ST, 32'h0);
        chk(rdat, 32'h0000_0010);
        apb(1'b0, 8'h18, 32'h0);
        chk({rerr, rdat[30:0]}, 32'h8000_0000);
        // Second reset in mid-run must bring both active-low flags back high
        NRST <= 1'b0;
        repeat (5) @(posedge CLK);
        NRST <= 1'b1;
        apb(1'b0, ST, 32'h0);
        chk(rdat, 32'h0000_0018);
        chk({31'h0, OSC_RUN}, 32'h1);
        wrap_up();
    end
endmodule // rss_core_tb_top

// ### hw/rss_core.v
// Rotate, subtract-from-literal and sleep datapath slice with an APB register port
//
// Contract
// - Rotate left: bits move up, old carry into bit 0, old bit 7 to carry.
// - Rotate right: bits move down, old carry into bit 7, old bit 0 to carry.
// - Rotate with destination 0 writes working register, file register untouched.
// - Rotate left with destination 1 writes result back to the file register.
// - Rotate right with destination 1 writes result back to the file register.
// - Sleep clears the power-down flag and sets the time-out flag.
// - Sleep clears the watchdog counter and its prescaler.
// - Sleep halts the oscillator; nothing executes until wake-up.
// - Subtract-from-literal computes literal minus working register, two's complement.
// - Subtract result goes to the working register only.
`timescale 1ns/1ps
`include "rss_map.vh"

module rss_core #(
    parameter FILE_DEPTH = 128,
    parameter FADR_W = 7,
    parameter PRE_W = 8,
    parameter WDOG_W = 8
) (
    input wire CLK,
    input wire NRST,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire WAKE,
    output reg OSC_RUN
);

    // ****************************************
    // State
    // ****************************************
    reg [7:0] file_mem [0:FILE_DEPTH-1];
    reg [7:0] w_reg;
    reg carry_reg;
    reg dcarry_reg;
    reg zero_reg;
    reg powerdown_flag_n_reg;
    reg timeout_flag_n_reg;
    reg asleep_reg;
    reg [FADR_W-1:0] faddr_reg;
    reg [PRE_W-1:0] prescale_reg;
    reg [WDOG_W-1:0] watchdog_counter_reg;

    reg [31:0] prdata_next;
    reg pslverr_next;
    wire pready_next;
    integer i;

    // ****************************************
    // Command decode
    // ****************************************
    wire access = PSEL & PENABLE;
    wire wr_commit = access & PREADY & PWRITE & ~PSLVERR;
    wire hit_cmd = (PADDR == `RSS_OFS_CMD);
    wire hit_w = (PADDR == `RSS_OFS_WREG);
    wire hit_st = (PADDR == `RSS_OFS_STATUS);
    wire hit_fa = (PADDR == `RSS_OFS_FADDR);
    wire hit_fd = (PADDR == `RSS_OFS_FDATA);
    wire hit_wd = (PADDR == `RSS_OFS_WDOG);
    wire mapped = hit_cmd | hit_w | hit_st | hit_fa | hit_fd | hit_wd;

    wire [FADR_W-1:0] cmd_fadr = PWDATA[`RSS_CMD_FADR_MSB:`RSS_CMD_FADR_LSB];
    wire cmd_dest = PWDATA[`RSS_CMD_DEST_BIT];
    wire [1:0] cmd_op = PWDATA[`RSS_CMD_OP_MSB:`RSS_CMD_OP_LSB];
    wire [7:0] cmd_lit = PWDATA[`RSS_CMD_LIT_MSB:`RSS_CMD_LIT_LSB];
    wire exec = wr_commit & hit_cmd;

    // ****************************************
    // Datapath
    // ****************************************
    wire [7:0] rot_out;
    wire rot_carry;

    rss_rotator #(
        .WIDTH(`RSS_DATA_W)
    ) u_rot (
        .data_in(file_mem[cmd_fadr]),
        .carry_in(carry_reg),
        .to_right(cmd_op == `RSS_OP_ROT_RIGHT),
        .data_out(rot_out),
        .carry_out(rot_carry)
    );

    // Extra top bit captures the borrow out of each subtraction
    wire [8:0] sub_full = {1'b0, cmd_lit} - {1'b0, w_reg};
    wire [4:0] sub_nib = {1'b0, cmd_lit[`RSS_NIB_MSB:0]} - {1'b0, w_reg[`RSS_NIB_MSB:0]};

    // ****************************************
    // APB answer, one wait state
    // ****************************************
    assign pready_next = access & ~PREADY;

    always @* begin
        prdata_next = `RSS_WORD_ZERO;
        pslverr_next = 1'b0;
        if (!mapped) begin
            pslverr_next = 1'b1;
        end else if (PWRITE && hit_cmd && asleep_reg) begin
            // Core is halted, so a launched instruction would be lost
            pslverr_next = 1'b1;
        end else if (!PWRITE) begin
            if (hit_w) begin
                prdata_next[7:0] = w_reg;
            end else if (hit_st) begin
                prdata_next[`RSS_ST_CARRY] = carry_reg;
                prdata_next[`RSS_ST_DCARRY] = dcarry_reg;
                prdata_next[`RSS_ST_ZERO] = zero_reg;
                prdata_next[`RSS_ST_POWERDOWN_N] = powerdown_flag_n_reg;
                prdata_next[`RSS_ST_TO_N] = timeout_flag_n_reg;
                prdata_next[`RSS_ST_ASLEEP] = asleep_reg;
            end else if (hit_fa) begin
                prdata_next[FADR_W-1:0] = faddr_reg;
            end else if (hit_fd) begin
                prdata_next[7:0] = file_mem[faddr_reg];
            end else if (hit_wd) begin
                prdata_next[WDOG_W-1:0] = watchdog_counter_reg;
                prdata_next[`RSS_WDOG_PRE_LSB+PRE_W-1:`RSS_WDOG_PRE_LSB] = prescale_reg;
            end
        end
    end

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            PREADY <= 1'b0;
            PRDATA <= `RSS_WORD_ZERO;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= pready_next;
            if (pready_next) begin
                PRDATA <= prdata_next;
                PSLVERR <= pslverr_next;
            end else begin
                PRDATA <= `RSS_WORD_ZERO;
                PSLVERR <= 1'b0;
            end
        end
    end

    // ****************************************
    // Working register and flags
    // ****************************************
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            w_reg <= `RSS_BYTE_ZERO;
            carry_reg <= 1'b0;
            dcarry_reg <= 1'b0;
            zero_reg <= 1'b0;
            faddr_reg <= {FADR_W{1'b0}};
        end else if (exec) begin
            case (cmd_op)
                `RSS_OP_ROT_LEFT, `RSS_OP_ROT_RIGHT: begin
                    // Only carry moves; digit carry and zero stay
                    carry_reg <= rot_carry;
                    if (!cmd_dest) begin
                        w_reg <= rot_out;
                    end
                end
                `RSS_OP_SUB_LIT: begin
                    w_reg <= sub_full[7:0];
                    carry_reg <= ~sub_full[`RSS_BYTE_CARRY];
                    dcarry_reg <= ~sub_nib[`RSS_NIB_CARRY];
                    zero_reg <= (sub_full[7:0] == `RSS_BYTE_ZERO);
                end
                default: begin
                end
            endcase
        end else if (wr_commit) begin
            if (hit_w) begin
                w_reg <= PWDATA[7:0];
            end
            if (hit_st) begin
                carry_reg <= PWDATA[`RSS_ST_CARRY];
                dcarry_reg <= PWDATA[`RSS_ST_DCARRY];
                zero_reg <= PWDATA[`RSS_ST_ZERO];
            end
            if (hit_fa) begin
                faddr_reg <= PWDATA[FADR_W-1:0];
            end
        end
    end

    // ****************************************
    // File registers
    // ****************************************
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            for (i = 0; i < FILE_DEPTH; i = i + 1) begin
                file_mem[i] <= `RSS_BYTE_ZERO;
            end
        end else if (exec && cmd_dest) begin
            if (cmd_op == `RSS_OP_ROT_LEFT) begin
                file_mem[cmd_fadr] <= rot_out;
            end else if (cmd_op == `RSS_OP_ROT_RIGHT) begin
                file_mem[cmd_fadr] <= rot_out;
            end
        end else if (wr_commit && hit_fd) begin
            file_mem[faddr_reg] <= PWDATA[7:0];
        end
    end

    // ****************************************
    // Sleep, wake and watchdog
    // ****************************************
    wire do_sleep = exec && (cmd_op == `RSS_OP_SLEEP);

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            powerdown_flag_n_reg <= `RSS_FLAG_N_RESET;
            timeout_flag_n_reg <= `RSS_FLAG_N_RESET;
            asleep_reg <= 1'b0;
            OSC_RUN <= 1'b1;
        end else if (do_sleep) begin
            // Entering sleep wins over a wake seen in the same cycle
            powerdown_flag_n_reg <= 1'b0;
            timeout_flag_n_reg <= 1'b1;
            asleep_reg <= 1'b1;
            OSC_RUN <= 1'b0;
        end else if (asleep_reg && WAKE) begin
            asleep_reg <= 1'b0;
            OSC_RUN <= 1'b1;
        end
    end

    // Counting stops while the oscillator is halted
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            prescale_reg <= {PRE_W{1'b0}};
            watchdog_counter_reg <= {WDOG_W{1'b0}};
        end else if (do_sleep) begin
            prescale_reg <= {PRE_W{1'b0}};
            watchdog_counter_reg <= {WDOG_W{1'b0}};
        end else if (!asleep_reg) begin
            prescale_reg <= prescale_reg + {{(PRE_W-1){1'b0}}, 1'b1};
            if (&prescale_reg) begin
                watchdog_counter_reg <= watchdog_counter_reg + {{(WDOG_W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule // rss_core

// ### hw/rss_rotator.v
// One-position rotate through carry, either direction
`timescale 1ns/1ps

module rss_rotator #(
    parameter WIDTH = 8
) (
    input wire [WIDTH-1:0] data_in,
    input wire carry_in,
    input wire to_right,
    output reg [WIDTH-1:0] data_out,
    output reg carry_out
);

    always @* begin
        if (to_right) begin
            data_out = {carry_in, data_in[WIDTH-1:1]};
            carry_out = data_in[0];
        end else begin
            data_out = {data_in[WIDTH-2:0], carry_in};
            carry_out = data_in[WIDTH-1];
        end
    end

endmodule // rss_rotator

// ### inc/rss_map.vh
// Register map, field positions, opcodes and reset values of the rotate/subtract/sleep slice
`ifndef RSS_MAP_VH
`define RSS_MAP_VH

// ****************************************
// Register byte offsets
// ****************************************
`define RSS_OFS_CMD 8'h00
`define RSS_OFS_WREG 8'h04
`define RSS_OFS_STATUS 8'h08
`define RSS_OFS_FADDR 8'h0c
`define RSS_OFS_FDATA 8'h10
`define RSS_OFS_WDOG 8'h14

// ****************************************
// Command word fields
// ****************************************
`define RSS_CMD_FADR_LSB 0
`define RSS_CMD_FADR_MSB 6
`define RSS_CMD_DEST_BIT 7
`define RSS_CMD_OP_LSB 8
`define RSS_CMD_OP_MSB 9
`define RSS_CMD_LIT_LSB 16
`define RSS_CMD_LIT_MSB 23

// ****************************************
// Opcodes
// ****************************************
`define RSS_OP_ROT_LEFT 2'h0
`define RSS_OP_ROT_RIGHT 2'h1
`define RSS_OP_SUB_LIT 2'h2
`define RSS_OP_SLEEP 2'h3

// ****************************************
// Status word fields
// ****************************************
`define RSS_ST_CARRY 0
`define RSS_ST_DCARRY 1
`define RSS_ST_ZERO 2
`define RSS_ST_POWERDOWN_N 3
`define RSS_ST_TO_N 4
`define RSS_ST_ASLEEP 5

// ****************************************
// Widths, positions and reset values
// ****************************************
`define RSS_DATA_W 8
`define RSS_NIB_MSB 3
`define RSS_NIB_CARRY 4
`define RSS_BYTE_CARRY 8
`define RSS_WDOG_PRE_LSB 8
`define RSS_BYTE_ZERO 8'h00
`define RSS_WORD_ZERO 32'h0000_0000
`define RSS_FLAG_N_RESET 1'b1

`endif
